// ==== rtl/dram_wait_refresh_pkg.sv ====
/*
 * package for the dram wait/refresh control block: timing counts and
 * bus status bundle.
 * assumes a single 50 MHz clock; all bus pins arrive asynchronously.
 */
package dram_wait_refresh_pkg;
	localparam int CLK_NS = 20;
	// delayed phase-2 edge after the blocked edge
	localparam int DELAY_NS = 30;
	localparam int DELAY_CYC = (DELAY_NS + CLK_NS - 1) / CLK_NS;
	// busy flag lingers after the cycle resets
	localparam int BUSY_TAIL_NS = 100;
	localparam int BUSY_TAIL_CYC = (BUSY_TAIL_NS + CLK_NS - 1) / CLK_NS;
	// memory / refresh cycle length
	localparam int CYCLE_NS = 520;
	localparam int CYCLE_CYC = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
	// spontaneous refresh interval, low end of 4-6 usec
	localparam int SPONT_US = 4;
	localparam int SPONT_CYC = (SPONT_US * 1000) / CLK_NS;
	localparam int CNT_W = 8;
	localparam int TMR_W = 8;
	localparam logic [CNT_W-1:0] CYCLE_LEN = CNT_W'(CYCLE_CYC);
	localparam logic [CNT_W-1:0] BUSY_TAIL = CNT_W'(BUSY_TAIL_CYC);
	localparam logic [CNT_W-1:0] DELAY_LEN = CNT_W'(DELAY_CYC);
	localparam logic [TMR_W-1:0] SPONT_LEN = TMR_W'(SPONT_CYC);

	typedef struct packed {
		logic phi2;
		logic sync;
		logic sel;
		logic memr;
		logic wo_n;
		logic prot;
		logic store_end;
	} bus_in_t;
endpackage : dram_wait_refresh_pkg

// ==== rtl/refresh_timer.sv ====
/*
 * spontaneous refresh timer: counts clock cycles since the last refresh
 * and pulses a trigger; assumes restart/inhibit come from the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module refresh_timer (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic enable,
	input wire logic restart,
	input wire logic inhibit,
	output logic fire
);
	typedef struct packed {
		logic [dram_wait_refresh_pkg::TMR_W-1:0] cnt;
		logic fire;
	} tmr_t;
	tmr_t st_ff;
	tmr_t nxt_st;

	// counter restarts at every refresh, fires once the interval elapses [RL18] [RL24]
	always_comb begin
		nxt_st = st_ff;
		nxt_st.fire = 1'b0;
		if (restart || !enable) begin
			nxt_st.cnt = '0;
		end else if (st_ff.cnt >= dram_wait_refresh_pkg::SPONT_LEN) begin
			if (!inhibit) begin // blocked while busy or a write is pending [RL19]
				nxt_st.fire = 1'b1;
				nxt_st.cnt = '0;
			end
		end else begin
			nxt_st.cnt = st_ff.cnt + 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign fire = st_ff.fire;

	a_fire_blocked: assert property (@(posedge clk) disable iff (!rst_b) // [RL19]
		(inhibit && !restart) |=> !fire)
		else $error("timer fired while inhibited");
endmodule : refresh_timer
`default_nettype wire

// ==== rtl/dram_wait_refresh_control.sv ====
/*
 * wait-state and refresh control of a dynamic memory board on a processor
 * bus: wait hold flag, one-wait option, memory/refresh cycle sequencing.
 * assumes bus pins asynchronous to MCLK; the board has no reset of its own,
 * so RST_B only initialises the emulation.
 */
//  Function
// RL1 - ready line follows wait hold; jumper picks line
// RL2 - wait held and selected requests wait
// RL3 - normal refreshes synchronous only, no wait
// RL4 - permit blocks spontaneous refresh; busy blocks too
// RL5 - phi2 fall in sync starts cycle or waits
// RL6 - coincident refresh start sets wait hold
// RL7 - wait hold cleared unless selected or sync
// RL8 - ready pulled low only when selected
// RL9 - busy refresh blocks memory cycle start
// RL10 - blocked cycle sets wait hold after delay
// RL11 - refresh end starts cycle, clears wait hold
// RL12 - processor waits after T2, resumes T3
// RL13 - option jumper holds option flop reset
// RL14 - option flop clocked one clock later
// RL15 - processor samples ready only in T2/wait
// RL16 - option flop reset extended while blocked
// RL17 - refresh lasts as long as refresh active
// RL18 - spontaneous timer restarts, fires after interval
// RL19 - timer disabled by busy or permit cleared
// RL20 - busy end with pending refresh starts refresh
// RL21 - memory read sync end marks refresh pending
// RL22 - write sync end clears refresh permit
// RL23 - busy spans cycle plus tail, blocks starts
// RL24 - timer is clocked counter, synchronized trigger
`timescale 1ns/100ps
`default_nettype none
module dram_wait_refresh_control (
	input wire logic MCLK,
	input wire logic RST_B,
	input wire logic PHI2,
	input wire logic SYNC,
	input wire logic BOARD_SEL,
	input wire logic STAT_MEMR,
	input wire logic STAT_WO_N,
	input wire logic WRITE_PROTECT,
	input wire logic STORE_END,
	input wire logic READY_SELECT_EXT,
	input wire logic WAIT_OPTION,
	input wire logic SPONT_ENABLE,
	output logic PROC_READY_N,
	output logic EXT_READY_N,
	output logic MEMORY_CYCLE,
	output logic REFRESH_ACTIVE,
	output logic TRANSACTION_BUSY,
	output logic WAIT_HOLD
);
	typedef struct packed {
		dram_wait_refresh_pkg::bus_in_t s1;
		dram_wait_refresh_pkg::bus_in_t s2;
		dram_wait_refresh_pkg::bus_in_t s3;
		dram_wait_refresh_pkg::bus_in_t flt;
		logic wait_hold_flag;
		logic memory_cycle;
		logic refresh_active;
		logic spont;
		logic transaction_busy;
		logic scheduled_refresh_n;
		logic refresh_permit;
		logic wait_option_flop;
		logic [dram_wait_refresh_pkg::CNT_W-1:0] cyc_cnt;
		logic [dram_wait_refresh_pkg::CNT_W-1:0] tail_cnt;
		logic [dram_wait_refresh_pkg::CNT_W-1:0] dly_cnt;
		logic dly_arm;
		logic dly_set;
		logic phi2_q;
		logic sync_q;
		logic trig_q;
		logic prdy_n;
		logic xrdy_n;
	} state_t;

	state_t st_ff;
	state_t nxt_st;
	logic timer_fire;
	logic timer_restart;
	logic timer_inhibit;
	dram_wait_refresh_pkg::bus_in_t pins;
	dram_wait_refresh_pkg::bus_in_t bus;

	assign pins = '{phi2: PHI2, sync: SYNC, sel: BOARD_SEL, memr: STAT_MEMR,
		wo_n: STAT_WO_N, prot: WRITE_PROTECT, store_end: STORE_END};

	// a pin change counts only once the second and third stages agree;
	// otherwise the last agreed level stands, so a settling stage is ignored
	logic [$bits(dram_wait_refresh_pkg::bus_in_t)-1:0] agreed;
	for (genvar b = 0; b < $bits(dram_wait_refresh_pkg::bus_in_t); b++) begin : g_agree
		assign agreed[b] = (st_ff.s2[b] == st_ff.s3[b]) ? st_ff.s3[b] : st_ff.flt[b];
	end
	assign bus = agreed;

	// spontaneous refresh timer, restarted while a refresh runs
	assign timer_restart = st_ff.refresh_active;
	assign timer_inhibit = st_ff.transaction_busy || !st_ff.refresh_permit; // [RL4] [RL19]

	refresh_timer u_timer (
		.clk(MCLK),
		.rst_b(RST_B),
		.enable(SPONT_ENABLE),
		.restart(timer_restart),
		.inhibit(timer_inhibit),
		.fire(timer_fire)
	);

	logic phi2_fall;
	logic sync_end;
	logic start_refresh;
	logic want_ready;
	logic opt_wait;

	assign phi2_fall = st_ff.phi2_q && !bus.phi2;
	assign sync_end = st_ff.sync_q && !bus.sync;

	// next-state logic for all flags
	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = pins;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		nxt_st.flt = bus;
		nxt_st.phi2_q = bus.phi2;
		nxt_st.sync_q = bus.sync;
		nxt_st.trig_q = timer_fire; // same-clock stage before trigger is used [RL24]
		start_refresh = 1'b0;

		// memory / refresh cycle length; both reset by the same count [RL17]
		if (st_ff.memory_cycle || st_ff.refresh_active) begin
			if (st_ff.cyc_cnt >= dram_wait_refresh_pkg::CYCLE_LEN - 1'b1) begin
				nxt_st.memory_cycle = 1'b0;
				nxt_st.refresh_active = 1'b0;
				nxt_st.spont = 1'b0;
				nxt_st.cyc_cnt = '0;
				nxt_st.tail_cnt = dram_wait_refresh_pkg::BUSY_TAIL; // [RL23]
			end else begin
				nxt_st.cyc_cnt = st_ff.cyc_cnt + 1'b1;
			end
		end

		// busy tail ends the transaction 100 ns after the cycle [RL23]
		if (!st_ff.memory_cycle && !st_ff.refresh_active && st_ff.transaction_busy) begin
			if (st_ff.tail_cnt <= 1) begin
				nxt_st.transaction_busy = 1'b0;
				// pending synchronous refresh starts as busy ends [RL20] [RL3]
				if (!st_ff.scheduled_refresh_n) begin
					start_refresh = 1'b1;
				end
			end else begin
				nxt_st.tail_cnt = st_ff.tail_cnt - 1'b1;
			end
		end

		// spontaneous trigger, honoured only when idle and permitted [RL4]
		if (st_ff.trig_q && !st_ff.transaction_busy && st_ff.refresh_permit) begin
			start_refresh = 1'b1;
			nxt_st.spont = 1'b1;
			// coincidence: cycle starting at the same instant [RL6]
			if (phi2_fall && bus.sync) begin
				nxt_st.wait_hold_flag = 1'b1;
			end
		end

		if (start_refresh) begin
			nxt_st.refresh_active = 1'b1;
			nxt_st.transaction_busy = 1'b1;
			nxt_st.cyc_cnt = '0;
			nxt_st.scheduled_refresh_n = 1'b1; // one refresh per sync [RL21]
		end

		// phi2 falling in sync: start memory cycle unless busy or a refresh starts [RL5] [RL9] [RL11]
		if (phi2_fall && (bus.sync || st_ff.wait_hold_flag)) begin
			if (!st_ff.transaction_busy && !start_refresh) begin
				nxt_st.memory_cycle = 1'b1;
				nxt_st.transaction_busy = 1'b1;
				nxt_st.cyc_cnt = '0;
				nxt_st.dly_set = 1'b0; // delayed edge will clear wait hold [RL11]
			end else begin
				nxt_st.dly_set = bus.sync; // blocked: delayed edge sets it [RL10]
			end
			nxt_st.dly_arm = 1'b1;
			nxt_st.dly_cnt = dram_wait_refresh_pkg::DELAY_LEN;
		end else if (st_ff.dly_arm) begin
			if (st_ff.dly_cnt <= 1) begin
				nxt_st.dly_arm = 1'b0;
				if (st_ff.dly_set) begin
					nxt_st.wait_hold_flag = 1'b1; // [RL10] [RL5]
				end else if (st_ff.memory_cycle) begin
					nxt_st.wait_hold_flag = 1'b0; // [RL11]
				end
			end else begin
				nxt_st.dly_cnt = st_ff.dly_cnt - 1'b1;
			end
		end

		// held reset unless selected or sync present [RL7]
		if (!bus.sel && !bus.sync) begin
			nxt_st.wait_hold_flag = 1'b0;
		end

		// end of sync marks pending refresh on reads [RL21]
		if (sync_end && bus.memr) begin
			nxt_st.scheduled_refresh_n = 1'b0;
		end
		// end of a selected unprotected write's sync clears permit [RL22]
		if (sync_end && !bus.wo_n && bus.sel && !bus.prot) begin
			nxt_st.refresh_permit = 1'b0;
		end else if (bus.store_end) begin
			nxt_st.refresh_permit = 1'b1;
		end

		// wait option flop: reset in sync or while blocked, clocked on phi2 fall [RL13] [RL14] [RL16]
		if (!WAIT_OPTION) begin
			nxt_st.wait_option_flop = 1'b0;
		end else if (bus.sync || st_ff.wait_hold_flag) begin
			nxt_st.wait_option_flop = 1'b0;
		end else if (phi2_fall) begin
			nxt_st.wait_option_flop = 1'b1;
		end

		// ready line from wait hold, gated by select, routed by jumper [RL1] [RL2] [RL8]
		opt_wait = WAIT_OPTION && !nxt_st.wait_option_flop;
		want_ready = bus.sel && (nxt_st.wait_hold_flag || opt_wait);
		nxt_st.prdy_n = want_ready && !READY_SELECT_EXT;
		nxt_st.xrdy_n = want_ready && READY_SELECT_EXT;
	end

	// single state register
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			st_ff <= '0;
			st_ff.refresh_permit <= 1'b1;
			st_ff.scheduled_refresh_n <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs straight from flops; ready outputs high means pulled low
	assign PROC_READY_N = st_ff.prdy_n;
	assign EXT_READY_N = st_ff.xrdy_n;
	assign MEMORY_CYCLE = st_ff.memory_cycle;
	assign REFRESH_ACTIVE = st_ff.refresh_active;
	assign TRANSACTION_BUSY = st_ff.transaction_busy;
	assign WAIT_HOLD = st_ff.wait_hold_flag;

	// a ready request only ever comes from a selected board
	a_ready_select: assert property (@(posedge MCLK) disable iff (!RST_B) // [RL8]
		(PROC_READY_N || EXT_READY_N) |-> $past(bus.sel))
		else $error("ready without select");

	// the jumper routes the request to one line only
	a_ready_lines: assert property (@(posedge MCLK) disable iff (!RST_B) // [RL1]
		!(PROC_READY_N && EXT_READY_N))
		else $error("both ready lines driven");

	// processor line only with the jumper at processor ready
	a_ready_proc: assert property (@(posedge MCLK) disable iff (!RST_B) // [RL1]
		PROC_READY_N |-> !$past(READY_SELECT_EXT))
		else $error("processor ready on wrong jumper");

	// bus line only with the jumper at external ready
	a_ready_ext: assert property (@(posedge MCLK) disable iff (!RST_B) // [RL1]
		EXT_READY_N |-> $past(READY_SELECT_EXT))
		else $error("external ready on wrong jumper");

	// a held flag on a selected board always shows as a wait request
	a_wait_hold_rdy: assert property (@(posedge MCLK) disable iff (!RST_B) // [RL2]
		(WAIT_HOLD && $past(bus.sel)) |-> (PROC_READY_N || EXT_READY_N))
		else $error("wait hold did not request wait");

	// outside a selected access or sync the flag is held clear
	a_hold_clear: assert property (@(posedge MCLK) disable iff (!RST_B) // [RL7]
		(!bus.sel && !bus.sync) |=> !WAIT_HOLD)
		else $error("wait hold not cleared");

	// busy keeps a memory cycle apart from a refresh
	a_no_overlap: assert property (@(posedge MCLK) disable iff (!RST_B) // [RL9]
		!(MEMORY_CYCLE && REFRESH_ACTIVE))
		else $error("cycle and refresh overlap");

	// a memory cycle never starts while busy
	a_mc_not_busy: assert property (@(posedge MCLK) disable iff (!RST_B) // [RL9] [RL23]
		$rose(MEMORY_CYCLE) |-> !$past(TRANSACTION_BUSY))
		else $error("memory cycle started while busy");

	// a memory cycle starts only from a phase-2 fall
	a_mc_from_fall: assert property (@(posedge MCLK) disable iff (!RST_B) // [RL5]
		$rose(MEMORY_CYCLE) |-> $past(phi2_fall))
		else $error("memory cycle without phase-2 fall");

	// every cycle is covered by busy
	a_busy_cover: assert property (@(posedge MCLK) disable iff (!RST_B) // [RL23]
		(MEMORY_CYCLE || REFRESH_ACTIVE) |-> TRANSACTION_BUSY)
		else $error("cycle without busy");

	// busy lingers a fixed tail after a memory cycle
	a_busy_tail: assert property (@(posedge MCLK) disable iff (!RST_B) // [RL23]
		$fell(MEMORY_CYCLE) |-> TRANSACTION_BUSY [*5])
		else $error("busy tail too short");

	// a refresh stays active for at least 8 clocks once started
	a_refresh_len: assert property (@(posedge MCLK) disable iff (!RST_B) // [RL17]
		$rose(REFRESH_ACTIVE) |-> REFRESH_ACTIVE [*8])
		else $error("refresh too short");

	// with no pending refresh, permit cleared and not busy, no refresh may start
	a_permit_block: assert property (@(posedge MCLK) disable iff (!RST_B) // [RL4]
		(!st_ff.refresh_permit && st_ff.scheduled_refresh_n && !TRANSACTION_BUSY)
		|=> !$rose(REFRESH_ACTIVE))
		else $error("refresh during write setup");

	// a refresh from the idle state needs the permit
	a_spont_permit: assert property (@(posedge MCLK) disable iff (!RST_B) // [RL19] [RL4]
		($rose(REFRESH_ACTIVE) && !$past(TRANSACTION_BUSY)) |-> $past(st_ff.refresh_permit))
		else $error("spontaneous refresh without permit");

	// a selected unprotected write's sync end drops the permit
	a_permit_clear: assert property (@(posedge MCLK) disable iff (!RST_B) // [RL22]
		(sync_end && !bus.wo_n && bus.sel && !bus.prot) |=> !st_ff.refresh_permit)
		else $error("permit not cleared by write");

	// a read's sync end leaves a refresh pending
	a_pend_mark: assert property (@(posedge MCLK) disable iff (!RST_B) // [RL21]
		(sync_end && bus.memr) |=> !st_ff.scheduled_refresh_n)
		else $error("read did not mark refresh pending");

	// a blocked phase-2 fall in sync raises the flag after the delay
	a_blocked_hold: assert property (@(posedge MCLK) disable iff (!RST_B) // [RL10] [RL5]
		(phi2_fall && bus.sync && bus.sel && st_ff.transaction_busy) |-> ##3 WAIT_HOLD)
		else $error("blocked cycle did not set wait hold");

	// with the option jumper, sync holds the option flop reset
	a_option_reset: assert property (@(posedge MCLK) disable iff (!RST_B) // [RL13]
		(WAIT_OPTION && bus.sync) |=> !st_ff.wait_option_flop)
		else $error("option flop not reset");

	// with the option, a selected sync always requests a wait
	a_option_ready: assert property (@(posedge MCLK) disable iff (!RST_B) // [RL13] [RL2]
		(WAIT_OPTION && bus.sel && bus.sync) |=> (PROC_READY_N || EXT_READY_N))
		else $error("option did not request wait");
endmodule : dram_wait_refresh_control
`default_nettype wire

// ==== dv/bus_master_model.sv ====
/*
 * processor bus master model: free-running phase-2 clock and one-cycle
 * read/write transfers. assumes clk is the 50 MHz bench clock.
 */
`timescale 1ns/100ps
`default_nettype none
module bus_master_model (
	input wire logic clk,
	input wire logic wait_req,
	output logic phi2,
	output logic sync,
	output logic sel,
	output logic memr,
	output logic wo_n
);
	logic [4:0] ph_ff;

	initial begin
		ph_ff = 5'h00;
		phi2 = 1'b1;
		sync = 1'b0;
		sel = 1'b0;
		memr = 1'b0;
		wo_n = 1'b1;
	end

	// 500 ns processor clock, high for the first 200 ns
	always @(negedge clk) begin
		ph_ff <= (ph_ff == 5'h18) ? 5'h00 : ph_ff + 5'h01;
		phi2 <= (ph_ff < 5'h09) || (ph_ff == 5'h18);
	end

	// one transfer: status with sync in T1, ready looked at only at phi2 falls
	task automatic run_cycle(input logic s, input logic r, input logic w, output int waits);
		waits = 0;
		do @(negedge clk); while (ph_ff != 5'h00);
		sync = 1'b1;
		sel = s;
		memr = r;
		wo_n = w;
		@(negedge clk);
		do @(negedge clk); while (ph_ff != 5'h00);
		sync = 1'b0;
		// lines stay put through every wait state
		do begin
			do @(negedge clk); while (ph_ff != 5'h09);
			waits += int'(wait_req);
		end while (wait_req && waits < 40);
		sel = 1'b0;
	endtask : run_cycle
endmodule : bus_master_model
`default_nettype wire

// ==== dv/dram_wait_refresh_control_tb_top.sv ====
/*
 * self-checking bench for the wait/refresh control block.
 * assumes the bus master model drives phi2, sync, sel, memr and wo_n; the bench drives prot and store_end itself.
 */
`timescale 1ns/100ps
`default_nettype none
module dram_wait_refresh_control_tb_top;
	logic mclk = 1'b0, rst_b = 1'b0, store_end = 1'b0;
	logic ext_sel = 1'b0, wait_opt = 1'b0, spont_en = 1'b0, proc_seen = 1'b0, prot = 1'b0;
	logic phi2, sync, sel, memr, wo_n, pr_n, xr_n, mc, ra, busy, wh;
	int failures = 0, n_compared = 0, cycles = 0, ra_len = 0, ra_last = 0;
	int n_ra = 0, waits, n, k;
	int mc_len = 0, mc_last = 0, bz_len = 0, bz_last = 0;

	always #10 mclk = ~mclk;

	dram_wait_refresh_control dram_wait_refresh_control_i (
		.MCLK(mclk), .RST_B(rst_b), .PHI2(phi2), .SYNC(sync), .BOARD_SEL(sel),
		.STAT_MEMR(memr), .STAT_WO_N(wo_n), .WRITE_PROTECT(prot), .STORE_END(store_end),
		.READY_SELECT_EXT(ext_sel), .WAIT_OPTION(wait_opt), .SPONT_ENABLE(spont_en),
		.PROC_READY_N(pr_n), .EXT_READY_N(xr_n), .MEMORY_CYCLE(mc),
		.REFRESH_ACTIVE(ra), .TRANSACTION_BUSY(busy), .WAIT_HOLD(wh)
	);

	bus_master_model bus_master_model_i (
		.clk(mclk), .wait_req(pr_n | xr_n), .phi2(phi2), .sync(sync), .sel(sel),
		.memr(memr), .wo_n(wo_n)
	);

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic await_ra(output int cnt);
		cnt = 0;
		while (ra !== 1'b1 && cnt < 1000) begin
			@(negedge mclk);
			cnt++;
		end
	endtask : await_ra

	task automatic complete_run();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run

	// cycle, refresh and busy lengths, refresh count, wrong-line requests, hang cut-off;
	// sampled on the falling edge, where the registered outputs have settled
	always @(negedge mclk) begin
		cycles <= cycles + 1;
		ra_len <= ra ? ra_len + 1 : 0;
		mc_len <= mc ? mc_len + 1 : 0;
		bz_len <= busy ? bz_len + 1 : 0;
		if (!ra && ra_len != 0) ra_last <= ra_len;
		if (!mc && mc_len != 0) mc_last <= mc_len;
		if (!busy && bz_len != 0) bz_last <= bz_len;
		if (ra && ra_len == 0) n_ra <= n_ra + 1;
		if ((pr_n === 1'b1 && ext_sel) || (xr_n === 1'b1 && !ext_sel)) proc_seen <= 1'b1;
		if (cycles == 20000) begin
			failures++;
			complete_run();
		end
	end

	// test sequence
	initial begin
		repeat (5) @(negedge mclk);
		rst_b = 1'b1;
		check("outputs after reset", 8'h00, {2'b00, pr_n, xr_n, mc, ra, busy, wh});
		bus_master_model_i.run_cycle(1'b1, 1'b1, 1'b1, waits);
		check("plain read waits", 8'h00, 8'(waits));
		await_ra(n);
		check("refresh after read", 8'h01, 8'(n < 60));
		repeat (100) @(negedge mclk);
		check("refresh length", dram_wait_refresh_pkg::CYCLE_LEN, 8'(ra_last));
		check("one refresh per sync", 8'h01, 8'(n_ra));
		check("memory cycle length", dram_wait_refresh_pkg::CYCLE_LEN, 8'(mc_last));
		n = 2 * (dram_wait_refresh_pkg::CYCLE_CYC + dram_wait_refresh_pkg::BUSY_TAIL_CYC);
		check("busy span", 8'(n), 8'(bz_last));
		$display("test read done");
		wait_opt = 1'b1;
		bus_master_model_i.run_cycle(1'b1, 1'b1, 1'b1, waits);
		check("option waits", 8'h01, 8'(waits));
		bus_master_model_i.run_cycle(1'b0, 1'b1, 1'b1, waits);
		check("unselected waits", 8'h00, 8'(waits));
		wait_opt = 1'b0;
		$display("test option done");
		repeat (100) @(negedge mclk);
		ext_sel = 1'b1;
		spont_en = 1'b1;
		await_ra(n);
		check("spontaneous refresh", 8'h01, 8'(n < 400));
		k = 0;
		for (int i = 0; i < 20; i++) begin
			bus_master_model_i.run_cycle(1'b1, 1'b0, 1'b1, waits);
			k += waits;
		end
		check("blocked cycle waits", 8'h01, 8'(k > 0));
		check("wait hold released", 8'h00, {7'h00, wh});
		check("wrong ready line quiet", 8'h00, {7'h00, proc_seen});
		$display("test collision done");
		bus_master_model_i.run_cycle(1'b1, 1'b0, 1'b0, waits);
		k = n_ra;
		repeat (400) @(negedge mclk);
		check("write holds refresh", 8'h00, 8'(n_ra - k));
		store_end = 1'b1;
		repeat (3) @(negedge mclk);
		store_end = 1'b0;
		await_ra(n);
		check("refresh after store", 8'h01, 8'(n < 400));
		$display("test write done");
		prot = 1'b1;
		bus_master_model_i.run_cycle(1'b1, 1'b0, 1'b0, waits);
		k = n_ra;
		repeat (400) @(negedge mclk);
		check("protected write keeps refresh", 8'h01, 8'(n_ra > k));
		$display("test protect done");
		complete_run();
	end
endmodule : dram_wait_refresh_control_tb_top
`default_nettype wire
